/* File: hdl/xcvr_params.svh */
// constants of the serial register and fifo port: offsets, field positions, reset values
// assumes inclusion by bare name from the package and the port modules
`ifndef XCVR_PARAMS_SVH
`define XCVR_PARAMS_SVH

// ==============================================================
// register offsets (7-bit address space)
`define XC_REG_FIFO 7'h00
`define XC_REG_CTRL 7'h01
`define XC_REG_PREAMBLE 7'h02
`define XC_REG_SYNC_HI 7'h03
`define XC_REG_SYNC_LO 7'h04
`define XC_REG_PKTCFG 7'h05
`define XC_REG_PAYLEN 7'h06
`define XC_REG_STATUS 7'h07

// ==============================================================
// control fields
`define XC_CTRL_PACKET 0
`define XC_CTRL_TX 1
`define XC_CTRL_ENABLE 2
// packet config fields
`define XC_PKT_LENMODE_LO 0
`define XC_PKT_CRC 2
`define XC_PKT_WHITEN 3
`define XC_PKT_LENHI_LO 4
// length modes
`define XC_LEN_FIXED 2'h0
`define XC_LEN_VARIABLE 2'h1
// status fields
`define XC_ST_EMPTY 0
`define XC_ST_FULL 1
`define XC_ST_OVERRUN 2
`define XC_ST_DONE 3
`define XC_ST_CRC_OK 4
`define XC_ST_TX_BUSY 5
`define XC_ST_RX_SYNC 6

// ==============================================================
// reset values and coding constants
`define XC_RST_PREAMBLE 8'h03
`define XC_RST_SYNC_HI 8'h2D
`define XC_RST_SYNC_LO 8'hD4
`define XC_PREAMBLE_BYTE 8'hAA
`define XC_CRC_INIT 16'hFFFF
`define XC_CRC_POLY 16'h1021
`define XC_PN_INIT 9'h1FF
`define XC_FIFO_DEPTH 4
`define XC_BYTE_W 8

`endif

/* File: hdl/xcvr_pkg.sv */
// types shared by the serial port and its packet engine
// assumes the constants header sits beside it
`include "xcvr_params.svh"

package xcvr_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] addr_t;
  typedef enum logic [2:0] {T_IDLE, T_PRE, T_SYNC, T_LEN, T_PAY, T_CRC, T_FIN} tx_state_t;
  typedef enum logic [1:0] {R_HUNT, R_LEN, R_PAY, R_CRC} rx_state_t;
endpackage

/* File: hdl/fifo_if.sv */
// valid/ready carrier between a buffer and its users
// assumes one clock shared by both sides
`timescale 1ns/1ns
`default_nettype none

interface fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport store (input wr_valid, input wr_data, input rd_ready,
                 output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
endinterface

`default_nettype wire

/* File: hdl/byte_fifo.sv */
// first-word-fall-through buffer with valid/ready on both sides
// assumes single clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  fifo_if.store f
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  // ==============================================================
  // flags and pointers
  assign f.wr_ready = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
  assign f.rd_valid = (wp_r != rp_r);
  assign f.rd_data = mem_r[rp_r[AW-1:0]];
  assign push = f.wr_valid && f.wr_ready;
  assign pop = f.rd_ready && f.rd_valid;

  always_comb
  begin
    wp_nxt = push ? wp_r + (AW+1)'(1) : wp_r;
    rp_nxt = pop ? rp_r + (AW+1)'(1) : rp_r;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (push)
      mem_r[wp_r[AW-1:0]] <= f.wr_data;
  end
endmodule

`default_nettype wire

/* File: hdl/xcvr_spi_port.sv */
// serial slave port to configuration registers and packet fifo, plus data path modes
// assumes serial pins synchronous to clk_in and sclk well below a quarter of clk_in
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: serial clock idles low, bits are sampled on its rising edge and shifted out on falling.
// R2: the port is slave only and never drives the serial clock or chip select.
// R3: a single write is an address byte then a data byte stored to that register.
// R4: a single read returns the addressed register during the byte after the address.
// R5: the host lowers chip select at frame start and raises it after the data byte.
// R6: in a burst the register address steps by one after each data byte.
// R7: bursts with address stepping work for both reads and writes.
// R8: for burst and fifo frames the host holds chip select low until the last byte.
// R9: a frame addressed to the fifo pushes written bytes or pops read bytes.
// R10: during fifo access the address stays fixed for the whole frame.
// R11: continuous and packet modes are selectable and each enables only its own path.
// R12: in continuous mode bits pass in real time through the continuous data pin.
// R13: packet mode adds preamble, sync, optional crc and whitening, and strips them on receive.
// R14: payload length is up to 255 with a length byte, 2047 fixed, or unlimited; tx sends PAYLEN as length byte but counts payload to rlen_r.
// R15: frames start with the write flag, then seven address bits, then data, msb first.
// R16: a written byte takes effect only after all eight bits; a cut byte is dropped.
`include "xcvr_params.svh"

module xcvr_spi_port (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic chip_select_n_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic continuous_data_pin_in,
  output logic continuous_data_pin_out,
  output logic continuous_data_pin_oe_out,
  output logic mod_bit_out,
  output logic mod_valid_out,
  input wire logic mod_ready_in,
  input wire logic demod_bit_in,
  input wire logic demod_valid_in
);
  import xcvr_pkg::*;

  fifo_if #(.W(`XC_BYTE_W)) f ();
  byte_fifo #(.W(`XC_BYTE_W), .D(`XC_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .f(f)
  );

  function automatic logic is_fifo(input addr_t a);
    is_fifo = (a == `XC_REG_FIFO);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `XC_CRC_POLY : 16'h0000);
  endfunction

  // ==============================================================
  // serial port and register file state
  byte_t cfg_r [128];
  byte_t cfg_nxt [128];
  logic sclk_d_r, sclk_d_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  byte_t shin_r, shin_nxt, shout_r, shout_nxt;
  addr_t addr_r, addr_nxt;
  logic wnr_r, wnr_nxt, in_data_r, in_data_nxt;
  logic miso_r, miso_nxt, miso_oe_r, miso_oe_nxt;
  logic spi_push, spi_pop;
  byte_t spi_wdata, rdval, full_byte, status;
  logic rise, fall;

  // ==============================================================
  // packet engine state
  tx_state_t tst_r, tst_nxt;
  rx_state_t rst_r, rst_nxt;
  byte_t tsh_r, tsh_nxt;
  logic [3:0] tcnt_r, tcnt_nxt;
  logic [10:0] tidx_r, tidx_nxt, ridx_r, ridx_nxt;
  logic twh_r, twh_nxt, tcrc_on_r, tcrc_on_nxt;
  logic [15:0] tcrc_r, tcrc_nxt, rcrc_r, rcrc_nxt, rsh_r, rsh_nxt;
  logic [8:0] tpn_r, tpn_nxt, rpn_r, rpn_nxt;
  logic [2:0] rcnt_r, rcnt_nxt;
  byte_t rlen_r, rlen_nxt;
  logic mod_bit_r, mod_bit_nxt, mod_valid_r, mod_valid_nxt;
  logic cd_r, cd_nxt, cd_oe_r, cd_oe_nxt;
  logic tx_fin, rx_fin, rx_crc_ok, rx_push, rx_over, tx_pop, tb, rb;
  byte_t rx_wdata, tbyte;
  logic [1:0] lenmode;
  logic [10:0] fixlen, paylen;
  logic pkt, txd, en, engine_wr, engine_rd;

  assign pkt = cfg_r[`XC_REG_CTRL][`XC_CTRL_PACKET];
  assign txd = cfg_r[`XC_REG_CTRL][`XC_CTRL_TX];
  assign en = cfg_r[`XC_REG_CTRL][`XC_CTRL_ENABLE];
  assign lenmode = cfg_r[`XC_REG_PKTCFG][`XC_PKT_LENMODE_LO +: 2];
  assign fixlen = {cfg_r[`XC_REG_PKTCFG][`XC_PKT_LENHI_LO +: 3], cfg_r[`XC_REG_PAYLEN]};
  assign engine_wr = pkt && !txd; // [R11]
  assign engine_rd = pkt && txd; // [R11]

  // ==============================================================
  // fifo ownership per mode
  assign f.wr_valid = engine_wr ? rx_push : spi_push;
  assign f.wr_data = engine_wr ? rx_wdata : spi_wdata;
  assign f.rd_ready = engine_rd ? tx_pop : spi_pop;

  assign status = {1'b0, rst_r != R_HUNT, tst_r != T_IDLE,
                   cfg_r[`XC_REG_STATUS][`XC_ST_OVERRUN +: 3], !f.wr_ready, !f.rd_valid};
  assign rdval = is_fifo(addr_r) ? (f.rd_valid ? f.rd_data : 8'h00) :
                 (addr_r == `XC_REG_STATUS) ? status : cfg_r[addr_r];

  // ==============================================================
  // serial slave: edges of host clock, no clock or select driven here [R2]
  always_comb
  begin
    rise = sclk_in && !sclk_d_r; // [R1]
    fall = !sclk_in && sclk_d_r; // [R1]
    cfg_nxt = cfg_r;
    sclk_d_nxt = sclk_in;
    bit_cnt_nxt = bit_cnt_r;
    shin_nxt = shin_r;
    shout_nxt = shout_r;
    addr_nxt = addr_r;
    wnr_nxt = wnr_r;
    in_data_nxt = in_data_r;
    miso_nxt = miso_r;
    miso_oe_nxt = !chip_select_n_in;
    spi_push = 1'b0;
    spi_pop = 1'b0;
    spi_wdata = 8'h00;
    full_byte = {shin_r[6:0], mosi_in};
    if (chip_select_n_in)
    begin
      // a partial byte is simply forgotten [R16]
      bit_cnt_nxt = 3'h0;
      in_data_nxt = 1'b0;
      miso_nxt = 1'b0;
      // no stale bits into the next address byte
      shout_nxt = 8'h00;
    end
    else if (rise)
    begin
      shin_nxt = full_byte; // [R15]
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7)
      begin
        if (!in_data_r)
        begin
          wnr_nxt = full_byte[7]; // [R15]
          addr_nxt = full_byte[6:0];
          in_data_nxt = 1'b1;
        end
        else
        begin
          if (wnr_r && is_fifo(addr_r))
          begin
            spi_push = 1'b1; // [R9] [R16]
            spi_wdata = full_byte;
          end
          else if (wnr_r && addr_r == `XC_REG_STATUS)
            cfg_nxt[addr_r] = cfg_r[addr_r] & ~(full_byte & 8'h0C);
          else if (wnr_r)
            cfg_nxt[addr_r] = full_byte; // [R3] [R16]
          if (!wnr_r && is_fifo(addr_r))
            spi_pop = 1'b1; // [R9]
          if (!is_fifo(addr_r))
            addr_nxt = addr_r + 7'h01; // [R6] [R7] [R10]
        end
      end
    end
    else if (fall)
    begin
      if (in_data_r && bit_cnt_r == 3'h0)
      begin
        miso_nxt = rdval[7]; // [R4] [R7]
        shout_nxt = {rdval[6:0], 1'b0};
      end
      else
      begin
        miso_nxt = shout_r[7]; // [R15]
        shout_nxt = {shout_r[6:0], 1'b0};
      end
    end
    // engine and host fifo overrun side effects on control and status, applied after host writes so they win
    if (tx_fin)
      cfg_nxt[`XC_REG_CTRL][`XC_CTRL_ENABLE] = 1'b0;
    if (tx_fin || rx_fin)
      cfg_nxt[`XC_REG_STATUS][`XC_ST_DONE] = 1'b1;
    if (rx_fin)
      cfg_nxt[`XC_REG_STATUS][`XC_ST_CRC_OK] = rx_crc_ok;
    if (rx_over || (spi_push && !engine_wr && !f.wr_ready))
      cfg_nxt[`XC_REG_STATUS][`XC_ST_OVERRUN] = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < 128; i++)
        cfg_r[i] <= 8'h00;
      cfg_r[`XC_REG_PREAMBLE] <= `XC_RST_PREAMBLE;
      cfg_r[`XC_REG_SYNC_HI] <= `XC_RST_SYNC_HI;
      cfg_r[`XC_REG_SYNC_LO] <= `XC_RST_SYNC_LO;
      sclk_d_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      shin_r <= 8'h00;
      shout_r <= 8'h00;
      addr_r <= 7'h00;
      wnr_r <= 1'b0;
      in_data_r <= 1'b0;
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      sclk_d_r <= sclk_d_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shin_r <= shin_nxt;
      shout_r <= shout_nxt;
      addr_r <= addr_nxt;
      wnr_r <= wnr_nxt;
      in_data_r <= in_data_nxt;
      miso_r <= miso_nxt;
      miso_oe_r <= miso_oe_nxt;
    end
  end

  // ==============================================================
  // data path: continuous pass-through and packet engine
  always_comb
  begin
    tst_nxt = tst_r;
    rst_nxt = rst_r;
    tsh_nxt = tsh_r;
    tcnt_nxt = tcnt_r;
    tidx_nxt = tidx_r;
    ridx_nxt = ridx_r;
    twh_nxt = twh_r;
    tcrc_on_nxt = tcrc_on_r;
    tcrc_nxt = tcrc_r;
    rcrc_nxt = rcrc_r;
    rsh_nxt = rsh_r;
    tpn_nxt = tpn_r;
    rpn_nxt = rpn_r;
    rcnt_nxt = rcnt_r;
    rlen_nxt = rlen_r;
    mod_bit_nxt = mod_bit_r;
    mod_valid_nxt = mod_valid_r && !mod_ready_in;
    cd_nxt = cd_r;
    cd_oe_nxt = en && !pkt && !txd;
    tx_fin = 1'b0;
    rx_fin = 1'b0;
    rx_crc_ok = 1'b0;
    rx_push = 1'b0;
    rx_over = 1'b0;
    rx_wdata = 8'h00;
    tx_pop = 1'b0;
    tbyte = 8'h00;
    tb = tsh_r[7];
    rb = demod_bit_in ^ (cfg_r[`XC_REG_PKTCFG][`XC_PKT_WHITEN] && rpn_r[0]);
    paylen = (lenmode == `XC_LEN_VARIABLE) ? {3'h0, rlen_r} : fixlen;
    if (!pkt)
    begin
      // raw bits bypass the fifo in real time [R12]
      tst_nxt = T_IDLE;
      rst_nxt = R_HUNT;
      mod_bit_nxt = continuous_data_pin_in; // [R12]
      mod_valid_nxt = en && txd;
      if (demod_valid_in)
        cd_nxt = demod_bit_in; // [R12]
    end
    else
    begin
      // transmit framing [R13]
      if (tcnt_r != 4'h0 && (!mod_valid_r || mod_ready_in))
      begin
        mod_bit_nxt = tb ^ (twh_r && tpn_r[0]);
        mod_valid_nxt = 1'b1;
        tsh_nxt = {tsh_r[6:0], 1'b0};
        tcnt_nxt = tcnt_r - 4'h1;
        if (tcrc_on_r)
          tcrc_nxt = crc_step(tcrc_r, tb);
        if (twh_r)
          tpn_nxt = {tpn_r[0] ^ tpn_r[5], tpn_r[8:1]};
      end
      else if (tcnt_r == 4'h0)
      begin
        case (tst_r)
          T_IDLE:
            if (en && txd && f.rd_valid)
            begin
              tst_nxt = T_PRE;
              tidx_nxt = 11'h000;
            end
          T_PRE:
          begin
            tbyte = `XC_PREAMBLE_BYTE;
            tcnt_nxt = 4'h8;
            twh_nxt = 1'b0;
            tcrc_on_nxt = 1'b0;
            tidx_nxt = tidx_r + 11'h001;
            if (tidx_r + 11'h001 >= {3'h0, cfg_r[`XC_REG_PREAMBLE]})
            begin
              tst_nxt = T_SYNC;
              tidx_nxt = 11'h000;
            end
          end
          T_SYNC:
          begin
            tbyte = tidx_r[0] ? cfg_r[`XC_REG_SYNC_LO] : cfg_r[`XC_REG_SYNC_HI];
            tcnt_nxt = 4'h8;
            tidx_nxt = 11'h001;
            tcrc_nxt = `XC_CRC_INIT;
            tpn_nxt = `XC_PN_INIT;
            if (tidx_r[0])
            begin
              tst_nxt = (lenmode == `XC_LEN_VARIABLE) ? T_LEN : T_PAY;
              tidx_nxt = 11'h000;
            end
          end
          T_LEN:
          begin
            tbyte = cfg_r[`XC_REG_PAYLEN]; // [R14]
            tcnt_nxt = 4'h8;
            twh_nxt = cfg_r[`XC_REG_PKTCFG][`XC_PKT_WHITEN];
            tcrc_on_nxt = 1'b1;
            tst_nxt = T_PAY;
          end
          T_PAY:
            if (f.rd_valid)
            begin
              tbyte = f.rd_data;
              tx_pop = 1'b1;
              tcnt_nxt = 4'h8;
              twh_nxt = cfg_r[`XC_REG_PKTCFG][`XC_PKT_WHITEN];
              tcrc_on_nxt = 1'b1;
              tidx_nxt = tidx_r + 11'h001;
              if (lenmode[1] == 1'b0 && tidx_r + 11'h001 >= paylen) // [R14]
                tst_nxt = cfg_r[`XC_REG_PKTCFG][`XC_PKT_CRC] ? T_CRC : T_FIN;
              if (lenmode[1] == 1'b0 && tidx_r + 11'h001 >= paylen)
                tidx_nxt = 11'h000;
            end
            else if (lenmode[1])
              tst_nxt = T_FIN; // [R14]
          T_CRC:
          begin
            tbyte = tidx_r[0] ? tcrc_r[7:0] : tcrc_r[15:8];
            tcnt_nxt = 4'h8;
            tcrc_on_nxt = 1'b0;
            tidx_nxt = 11'h001;
            if (tidx_r[0])
              tst_nxt = T_FIN;
          end
          T_FIN:
            if (!mod_valid_r || mod_ready_in)
            begin
              tst_nxt = T_IDLE;
              tx_fin = 1'b1;
            end
          default:
            tst_nxt = T_IDLE;
        endcase
        if (tcnt_nxt != 4'h0)
          tsh_nxt = tbyte;
      end
      // receive deframing [R13]
      if (!(en && !txd))
        rst_nxt = R_HUNT;
      else if (demod_valid_in)
      begin
        if (rst_r == R_HUNT)
        begin
          rsh_nxt = {rsh_r[14:0], demod_bit_in};
          if ({rsh_r[14:0], demod_bit_in} == {cfg_r[`XC_REG_SYNC_HI], cfg_r[`XC_REG_SYNC_LO]})
          begin
            rst_nxt = (lenmode == `XC_LEN_VARIABLE) ? R_LEN : R_PAY;
            rcnt_nxt = 3'h0;
            ridx_nxt = 11'h000;
            rcrc_nxt = `XC_CRC_INIT;
            rpn_nxt = `XC_PN_INIT;
          end
        end
        else
        begin
          rsh_nxt = {rsh_r[14:0], rb};
          rcnt_nxt = rcnt_r + 3'h1;
          rcrc_nxt = crc_step(rcrc_r, rb);
          if (cfg_r[`XC_REG_PKTCFG][`XC_PKT_WHITEN])
            rpn_nxt = {rpn_r[0] ^ rpn_r[5], rpn_r[8:1]};
          if (rcnt_r == 3'h7)
          begin
            ridx_nxt = ridx_r + 11'h001;
            case (rst_r)
              R_LEN:
              begin
                rlen_nxt = {rsh_r[6:0], rb}; // [R14]
                rst_nxt = R_PAY;
                ridx_nxt = 11'h000;
              end
              R_PAY:
              begin
                rx_wdata = {rsh_r[6:0], rb};
                rx_push = 1'b1;
                rx_over = !f.wr_ready;
                if (lenmode[1] == 1'b0 && ridx_r + 11'h001 >= paylen) // [R14]
                begin
                  rst_nxt = cfg_r[`XC_REG_PKTCFG][`XC_PKT_CRC] ? R_CRC : R_HUNT;
                  rx_fin = !cfg_r[`XC_REG_PKTCFG][`XC_PKT_CRC];
                  ridx_nxt = 11'h000;
                end
              end
              default:
                if (ridx_r[0])
                begin
                  rst_nxt = R_HUNT;
                  rx_fin = 1'b1;
                  rx_crc_ok = (crc_step(rcrc_r, rb) == 16'h0000);
                end
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      tst_r <= T_IDLE;
      rst_r <= R_HUNT;
      tsh_r <= 8'h00;
      tcnt_r <= 4'h0;
      tidx_r <= 11'h000;
      ridx_r <= 11'h000;
      twh_r <= 1'b0;
      tcrc_on_r <= 1'b0;
      tcrc_r <= `XC_CRC_INIT;
      rcrc_r <= `XC_CRC_INIT;
      rsh_r <= 16'h0000;
      tpn_r <= `XC_PN_INIT;
      rpn_r <= `XC_PN_INIT;
      rcnt_r <= 3'h0;
      rlen_r <= 8'h00;
      mod_bit_r <= 1'b0;
      mod_valid_r <= 1'b0;
      cd_r <= 1'b0;
      cd_oe_r <= 1'b0;
    end
    else
    begin
      tst_r <= tst_nxt;
      rst_r <= rst_nxt;
      tsh_r <= tsh_nxt;
      tcnt_r <= tcnt_nxt;
      tidx_r <= tidx_nxt;
      ridx_r <= ridx_nxt;
      twh_r <= twh_nxt;
      tcrc_on_r <= tcrc_on_nxt;
      tcrc_r <= tcrc_nxt;
      rcrc_r <= rcrc_nxt;
      rsh_r <= rsh_nxt;
      tpn_r <= tpn_nxt;
      rpn_r <= rpn_nxt;
      rcnt_r <= rcnt_nxt;
      rlen_r <= rlen_nxt;
      mod_bit_r <= mod_bit_nxt;
      mod_valid_r <= mod_valid_nxt;
      cd_r <= cd_nxt;
      cd_oe_r <= cd_oe_nxt;
    end
  end

  assign miso_out = miso_r;
  assign miso_oe_out = miso_oe_r;
  assign mod_bit_out = mod_bit_r;
  assign mod_valid_out = mod_valid_r;
  assign continuous_data_pin_out = cd_r;
  assign continuous_data_pin_oe_out = cd_oe_r;
endmodule

`default_nettype wire

/* File: sim/xcvr_spi_port_properties.sv */
// port checker for the serial slave port
// assumes bind onto xcvr_spi_port, one clock
`timescale 1ns/1ns
`default_nettype none

module spi_port_checker (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic chip_select_n_in,
  input wire logic miso_out,
  input wire logic miso_oe_out,
  input wire logic continuous_data_pin_out,
  input wire logic continuous_data_pin_oe_out,
  input wire logic mod_bit_out,
  input wire logic mod_valid_out,
  input wire logic demod_valid_in
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic sclk_r;
  // ==========
  // rising edges seen since select fell
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!nrst_in || chip_select_n_in)
      cnt_nxt = 4'h0;
    else if (sclk_in && !sclk_r && cnt_r < 4'h8)
      cnt_nxt = cnt_r + 4'h1;
  end
  always_ff @(posedge clk_in)
  begin
    cnt_r <= cnt_nxt;
    sclk_r <= sclk_in;
  end
  // ==========
  // properties
  sequence s_deselect;
    !chip_select_n_in ##1 chip_select_n_in;
  endsequence
  sequence s_idle2;
    chip_select_n_in [*2];
  endsequence
  property p_rst;
    @(posedge clk_in) !nrst_in |=> !miso_out && !miso_oe_out && !mod_valid_out
      && !mod_bit_out && !continuous_data_pin_out && !continuous_data_pin_oe_out;
  endproperty
  property p_oe_on;
    @(posedge clk_in) disable iff (!nrst_in) !chip_select_n_in |=> miso_oe_out;
  endproperty
  property p_oe_off;
    @(posedge clk_in) disable iff (!nrst_in) s_deselect |=> !miso_oe_out;
  endproperty
  property p_miso_idle;
    @(posedge clk_in) disable iff (!nrst_in) s_idle2 |-> !miso_out;
  endproperty
  property p_miso_edge;
    @(posedge clk_in) disable iff (!nrst_in)
      $changed(miso_out) && !chip_select_n_in && !$past(chip_select_n_in)
      |-> !$past(sclk_in) && $past(sclk_in, 2);
  endproperty
  property p_miso_addr;
    @(posedge clk_in) disable iff (!nrst_in)
      !chip_select_n_in && cnt_r < 4'h8 |-> !miso_out;
  endproperty
  property p_cont_pin;
    @(posedge clk_in) disable iff (!nrst_in)
      $changed(continuous_data_pin_out) |-> $past(demod_valid_in);
  endproperty
  property p_cont_oe;
    @(posedge clk_in) disable iff (!nrst_in) continuous_data_pin_oe_out |-> !mod_valid_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_oe_on: assert property (p_oe_on) else $error("miso enable missing");
  a_oe_off: assert property (p_oe_off) else $error("miso enable stuck");
  a_miso_idle: assert property (p_miso_idle) else $error("miso active unselected");
  a_miso_edge: assert property (p_miso_edge) else $error("miso moved off edge");
  a_miso_addr: assert property (p_miso_addr) else $error("miso set in address");
  a_cont_pin: assert property (p_cont_pin) else $error("data pin moved alone");
  a_cont_oe: assert property (p_cont_oe) else $error("rx pin with tx bits");
endmodule

bind xcvr_spi_port spi_port_checker chk (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .sclk_in(sclk_in),
  .chip_select_n_in(chip_select_n_in),
  .miso_out(miso_out),
  .miso_oe_out(miso_oe_out),
  .continuous_data_pin_out(continuous_data_pin_out),
  .continuous_data_pin_oe_out(continuous_data_pin_oe_out),
  .mod_bit_out(mod_bit_out),
  .mod_valid_out(mod_valid_out),
  .demod_valid_in(demod_valid_in)
);

`default_nettype wire

/* File: sim/spi_host.sv */
// host model acting as serial master, mode 0
// assumes clk_in of the port; drives at its falling edge
`timescale 1ns/1ns
`default_nettype none

module spi_host (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic mosi_out,
  output logic chip_select_n_out
);
  import xcvr_pkg::*;
  initial
  begin
    sclk_out = 1'b0;
    mosi_out = 1'b0;
    chip_select_n_out = 1'b1;
  end
  // ==========
  // frame edges
  task start();
    @(negedge clk_in) chip_select_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  task stop();
    repeat (4) @(negedge clk_in);
    chip_select_n_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (4) @(negedge clk_in);
  endtask
  // ==========
  // n bits msb first, sampled on rising sclk
  task bits(input byte_t tx, input int n, output byte_t rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      mosi_out = tx[i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      rx[i] = miso_in;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
  endtask
  task xfer(input byte_t tx, output byte_t rx);
    bits(tx, 8, rx);
  endtask
endmodule

`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the serial slave port
// assumes the host model and the port checker
`timescale 1ns/1ns
`default_nettype none
`include "xcvr_params.svh"

module tb;
  import xcvr_pkg::*;
  logic clk_in, nrst_in, sclk, mosi, cs_n, miso, miso_oe, cd_out, cd_oe, mod_bit, mod_valid;
  logic demod_bit, demod_valid, cd_in, mod_ready;
  int err_count, n_tests;
  byte_t rd;
  logic [31:0] mod_sh;
  xcvr_spi_port uut (.clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk), .mosi_in(mosi),
    .chip_select_n_in(cs_n), .miso_out(miso), .miso_oe_out(miso_oe),
    .continuous_data_pin_in(cd_in), .continuous_data_pin_out(cd_out),
    .continuous_data_pin_oe_out(cd_oe), .mod_bit_out(mod_bit), .mod_valid_out(mod_valid),
    .mod_ready_in(mod_ready), .demod_bit_in(demod_bit), .demod_valid_in(demod_valid));
  spi_host host (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk), .mosi_out(mosi),
    .chip_select_n_out(cs_n));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // bits taken by the modulator, latest last
  always @(negedge clk_in)
    if (mod_valid && mod_ready)
      mod_sh <= {mod_sh[30:0], mod_bit};
  // ==========
  // helpers
  task test_done();
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input byte_t got, input byte_t exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input addr_t a, input byte_t d);
    host.start();
    host.xfer({1'b1, a}, rd);
    host.xfer(d, rd);
    host.stop();
  endtask
  task rd1(input addr_t a, input byte_t exp);
    host.start();
    host.xfer({1'b0, a}, rd);
    host.xfer(8'h00, rd);
    host.stop();
    chk(rd, exp);
  endtask
  // ==========
  // scenarios
  task t_reset();
    host.start();
    host.xfer({1'b0, `XC_REG_PREAMBLE}, rd);
    host.xfer(8'h00, rd);
    chk(rd, `XC_RST_PREAMBLE);
    host.xfer(8'h00, rd);
    chk(rd, `XC_RST_SYNC_HI);
    host.xfer(8'h00, rd);
    chk(rd, `XC_RST_SYNC_LO);
    host.stop();
  endtask
  task t_single();
    wr(`XC_REG_PAYLEN, 8'h1E);
    rd1(`XC_REG_PAYLEN, 8'h1E);
  endtask
  task t_burst();
    host.start();
    host.xfer({1'b1, `XC_REG_PKTCFG}, rd);
    host.xfer(8'h36, rd);
    host.xfer(8'h81, rd);
    host.stop();
    rd1(`XC_REG_PKTCFG, 8'h36);
    rd1(`XC_REG_PAYLEN, 8'h81);
  endtask
  task t_cut();
    host.start();
    host.xfer({1'b1, `XC_REG_PAYLEN}, rd);
    host.bits(8'hF0, 4, rd);
    host.stop();
    rd1(`XC_REG_PAYLEN, 8'h81);
  endtask
  task t_fifo();
    host.start();
    host.xfer({1'b1, `XC_REG_FIFO}, rd);
    for (int i = 1; i <= 5; i++)
      host.xfer(byte_t'(8'h11 * i), rd);
    host.stop();
    rd1(`XC_REG_STATUS, 8'h06);
    host.start();
    host.xfer({1'b0, `XC_REG_FIFO}, rd);
    for (int i = 1; i <= 4; i++)
    begin
      host.xfer(8'h00, rd);
      chk(rd, byte_t'(8'h11 * i));
    end
    host.stop();
    rd1(`XC_REG_STATUS, 8'h05);
    wr(`XC_REG_STATUS, 8'h04);
    rd1(`XC_REG_STATUS, 8'h01);
  endtask
  task t_cont();
    wr(`XC_REG_CTRL, 8'h04);
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk_in) demod_bit = ~demod_bit;
      demod_valid = 1'b1;
      @(negedge clk_in) demod_valid = 1'b0;
      repeat (2) @(negedge clk_in);
      chk({7'h00, cd_out}, {7'h00, demod_bit});
      chk({7'h00, cd_oe}, 8'h01);
    end
    wr(`XC_REG_CTRL, 8'h00);
    chk({7'h00, cd_oe}, 8'h00);
    cd_in = 1'b1;
    wr(`XC_REG_CTRL, 8'h06);
    chk({6'h00, mod_valid, mod_bit}, 8'h03);
    cd_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk({6'h00, mod_valid, mod_bit}, 8'h02);
    chk({7'h00, cd_oe}, 8'h00);
  endtask
  task t_pkt();
    wr(`XC_REG_PKTCFG, 8'h00);
    wr(`XC_REG_PAYLEN, 8'h00);
    wr(`XC_REG_FIFO, 8'h5A);
    wr(`XC_REG_CTRL, 8'h07);
    repeat (80) @(negedge clk_in);
    chk(mod_sh[31:24], `XC_PREAMBLE_BYTE);
    chk(mod_sh[23:16], `XC_RST_SYNC_HI);
    chk(mod_sh[15:8], `XC_RST_SYNC_LO);
    chk(mod_sh[7:0], 8'h5A);
    rd1(`XC_REG_CTRL, 8'h03);
    rd1(`XC_REG_STATUS, 8'h09);
  endtask
  // ==========
  // main sequence and watchdog
  initial
  begin
    err_count = 0;
    n_tests = 0;
    nrst_in = 1'b0;
    demod_bit = 1'b0;
    demod_valid = 1'b0;
    cd_in = 1'b0;
    mod_ready = 1'b1;
    repeat (6) @(negedge clk_in);
    nrst_in = 1'b1;
    t_reset();
    t_single();
    t_burst();
    t_cut();
    t_fifo();
    t_cont();
    t_pkt();
    test_done();
  end
  initial
  begin
    #500000;
    err_count++;
    test_done();
  end
endmodule

`default_nettype wire
